// [logic/cpp_pkg.sv]
package cpp_pkg;

    // serial slave address and register map
    localparam logic [6:0] SLAVE_ADDR = 7'h48;
    localparam logic [7:0] REG_PPATH = 8'h01;
    localparam logic [7:0] REG_INT = 8'h02;
    localparam logic [7:0] REG_STATUS = 8'h03;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // reset values
    localparam logic [5:0] PPATH_RESET = 6'h0d;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [3:0] FLAG_RESET = 4'h0;
    localparam logic [7:0] CTRL_RESET = 8'h31;

    // flag positions inside the low nibble of the interrupt register
    localparam int FLAG_TOUCH = 3;
    localparam int FLAG_BUTTON = 2;
    localparam int FLAG_APPLIED = 1;
    localparam int FLAG_REMOVED = 0;

    // mask positions inside the three-bit mask field (register bits 7..5)
    localparam int MASK_INPUT = 2;
    localparam int MASK_TOUCH = 1;
    localparam int MASK_BUTTON = 0;

    // bits in one serial byte
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // current limits in mA and timer lengths in hours, indexed by field code
    localparam logic [11:0] ADAPTER_MA [4] = '{12'h064, 12'h1f4, 12'h514, 12'h9c4};
    localparam logic [11:0] USB_MA [4] = '{12'h064, 12'h1f4, 12'h320, 12'h514};
    localparam logic [3:0] TIMER_HOURS [4] = '{4'h4, 4'h5, 4'h6, 4'h8};

    // charger loop status as reported by the analog side
    typedef struct packed {
        logic thermal_reg;
        logic dynamic_power_path_loop;
        logic thermal_suspend;
        logic term_reached;
        logic fast_timeout;
        logic pre_timeout;
        logic no_thermistor;
    } cpp_status_s;

    // controls; bits 13..8 mirror power_path_control, 7..0 charger_control
    typedef struct packed {
        logic usb_suspend;
        logic adapter_suspend;
        logic [1:0] adapter_ilim;
        logic [1:0] usb_ilim;
        logic [1:0] timer_sel;
        logic timer_enable;
        logic thermistor_type;
        logic charger_reset;
        logic term_disable;
        logic timer_pause;
        logic charger_enable;
    } cpp_ctrl_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_RX = 3'b011,
        ST_RX_ACK = 3'b100,
        ST_TX = 3'b101,
        ST_TX_ACK = 3'b110
    } cpp_state_e;

endpackage

// [logic/cpp_regs.sv]
`timescale 1ns/100ps

// three-stage synchroniser; output follows once stages two and three agree
module cpp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // stage chain and agreement filter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q <= INIT;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
        end
    end
endmodule

module cpp_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // serial pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // interrupt pin, open drain
    output logic int_out,
    output logic int_oe,
    // sense inputs
    input wire logic usb_present,
    input wire logic adapter_present,
    input wire cpp_pkg::cpp_status_s charger_state,
    input wire logic touch_detect,
    input wire logic pushbutton_input_n,
    input wire logic button_active_high,
    // controls to the charger
    output cpp_pkg::cpp_ctrl_s ctrl,
    output logic [11:0] adapter_limit_ma,
    output logic [11:0] usb_limit_ma,
    output logic [3:0] timer_hours,
    output logic timer_clear
);
    logic scl_q, sda_q, usb_q, ad_q, touch_q, pb_q, pol_q;
    cpp_pkg::cpp_status_s stat_q;
    logic scl_d, sda_d, usb_d, ad_d, touch_d, btn_d;
    logic scl_rise, scl_fall, start, stop, btn_act;
    logic applied, removed, usb_rm, ad_rm, touch_rise, btn_rise;
    cpp_pkg::cpp_state_e state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [7:0] rd_byte;
    logic [7:0] wr_data;
    logic rw, have_ptr, nack, wr_en, rd_load, rd_clr, pending;
    logic [2:0] masks;
    logic [3:0] flags;
    logic [3:0] set_bits;
    logic [3:0] next_flags;

    // every pin input passes the three-stage filter
    // scl, sda and the active-low button pin idle high, so their stages start high to avoid a false edge
    cpp_sync #(.W(14), .INIT(14'h3100)) u_sync (
        .clk(mclk),
        .rstn(rstn),
        .d({scl, sda_in, usb_present, adapter_present, touch_detect, pushbutton_input_n,
            button_active_high, charger_state}),
        .q({scl_q, sda_q, usb_q, ad_q, touch_q, pb_q, pol_q, stat_q})
    );

    // previous filtered levels for edge detection
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            usb_d <= 1'b0;
            ad_d <= 1'b0;
            touch_d <= 1'b0;
            btn_d <= 1'b0;
        end else begin
            scl_d <= scl_q;
            sda_d <= sda_q;
            usb_d <= usb_q;
            ad_d <= ad_q;
            touch_d <= touch_q;
            btn_d <= btn_act;
        end
    end

    // bus conditions and source events
    assign scl_rise = scl_q & ~scl_d;
    assign scl_fall = ~scl_q & scl_d;
    assign start = scl_q & scl_d & sda_d & ~sda_q;
    assign stop = scl_q & scl_d & ~sda_d & sda_q;
    assign btn_act = pol_q ? pb_q : ~pb_q;
    assign usb_rm = ~usb_q & usb_d;
    assign ad_rm = ~ad_q & ad_d;
    assign applied = (usb_q & ~usb_d) | (ad_q & ~ad_d);
    assign removed = usb_rm | ad_rm;
    assign touch_rise = touch_q & ~touch_d;
    assign btn_rise = btn_act & ~btn_d;

    // read data mux; unmapped addresses read zero
    always_comb begin
        case (ptr)
            cpp_pkg::REG_PPATH: rd_byte = {usb_q, ad_q, ctrl[13:8]};
            cpp_pkg::REG_INT: rd_byte = {masks, 1'b0, flags};
            cpp_pkg::REG_STATUS: rd_byte = {stat_q[6:3], 1'b0, stat_q[2:0]};
            cpp_pkg::REG_CTRL: rd_byte = ctrl[7:0];
            default: rd_byte = cpp_pkg::UNMAPPED_DATA;
        endcase
    end

    // a byte is loaded for transmit at the falling edge ending an acknowledge
    assign rd_load = ~start & ~stop & scl_fall & rw &
                     ((state == cpp_pkg::ST_ADDR_ACK) | ((state == cpp_pkg::ST_TX_ACK) & ~nack));
    assign rd_clr = rd_load & (ptr == cpp_pkg::REG_INT);

    // serial slave state machine
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= cpp_pkg::ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            have_ptr <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start) begin
            state <= cpp_pkg::ST_ADDR;
            cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (stop) begin
            state <= cpp_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                cpp_pkg::ST_ADDR, cpp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_q};
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall && cnt == cpp_pkg::BYTE_BITS) begin
                        if (state == cpp_pkg::ST_RX) begin
                            sda_oe <= 1'b1;
                            state <= cpp_pkg::ST_RX_ACK;
                            if (!have_ptr) begin
                                ptr <= shreg;
                                have_ptr <= 1'b1;
                            end
                        end else if (shreg[7:1] == cpp_pkg::SLAVE_ADDR) begin
                            sda_oe <= 1'b1;
                            rw <= shreg[0];
                            have_ptr <= have_ptr & shreg[0];
                            state <= cpp_pkg::ST_ADDR_ACK;
                        end else begin
                            state <= cpp_pkg::ST_IDLE;
                        end
                    end
                end
                cpp_pkg::ST_ADDR_ACK, cpp_pkg::ST_TX_ACK, cpp_pkg::ST_RX_ACK: begin
                    if (scl_rise) begin
                        nack <= sda_q;
                    end else if (scl_fall) begin
                        cnt <= 4'h0;
                        if (rd_load) begin
                            sda_oe <= ~rd_byte[7];
                            tx <= {rd_byte[6:0], 1'b0};
                            state <= cpp_pkg::ST_TX;
                        end else if (state == cpp_pkg::ST_TX_ACK) begin
                            sda_oe <= 1'b0;
                            state <= cpp_pkg::ST_IDLE;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= cpp_pkg::ST_RX;
                        end
                    end
                end
                cpp_pkg::ST_TX: begin
                    if (scl_rise) begin
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == cpp_pkg::BYTE_BITS) begin
                            sda_oe <= 1'b0;
                            state <= cpp_pkg::ST_TX_ACK;
                        end else begin
                            sda_oe <= ~tx[7];
                            tx <= {tx[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // one-cycle write strobe for each data byte after the pointer
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_en <= 1'b0;
            wr_data <= 8'h00;
        end else begin
            wr_en <= ~start & ~stop & scl_fall & (state == cpp_pkg::ST_RX) &
                     (cnt == cpp_pkg::BYTE_BITS) & have_ptr;
            wr_data <= shreg;
        end
    end

    // control registers; a removed source reloads its own current limit
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl <= {cpp_pkg::PPATH_RESET, cpp_pkg::CTRL_RESET};
            masks <= cpp_pkg::MASK_RESET;
        end else begin
            if (wr_en && ptr == cpp_pkg::REG_PPATH) begin
                ctrl[13:8] <= wr_data[5:0];
            end
            if (wr_en && ptr == cpp_pkg::REG_CTRL) begin
                ctrl[7:0] <= wr_data;
            end
            if (wr_en && ptr == cpp_pkg::REG_INT) begin
                masks <= wr_data[7:5];
            end
            if (ad_rm) begin
                ctrl.adapter_ilim <= cpp_pkg::PPATH_RESET[3:2];
            end
            if (usb_rm) begin
                ctrl.usb_ilim <= cpp_pkg::PPATH_RESET[1:0];
            end
        end
    end

    // sticky flags; a new event wins over the read clear
    assign set_bits = {touch_rise, btn_rise, applied, removed};
    assign next_flags = (flags & ~{4{rd_clr}}) | set_bits;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            flags <= cpp_pkg::FLAG_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // open-drain interrupt, enabled while an unmasked flag is pending
    assign pending = (masks[cpp_pkg::MASK_INPUT] & (flags[cpp_pkg::FLAG_APPLIED] | flags[cpp_pkg::FLAG_REMOVED])) |
                     (masks[cpp_pkg::MASK_TOUCH] & flags[cpp_pkg::FLAG_TOUCH]) |
                     (masks[cpp_pkg::MASK_BUTTON] & flags[cpp_pkg::FLAG_BUTTON]);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            int_oe <= 1'b0;
            int_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            int_oe <= pending;
            int_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // decoded limits, timer length and timer clear
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            adapter_limit_ma <= 12'h000;
            usb_limit_ma <= 12'h000;
            timer_hours <= 4'h0;
            timer_clear <= 1'b0;
        end else begin
            adapter_limit_ma <= cpp_pkg::ADAPTER_MA[ctrl.adapter_ilim];
            usb_limit_ma <= cpp_pkg::USB_MA[ctrl.usb_ilim];
            timer_hours <= cpp_pkg::TIMER_HOURS[ctrl.timer_sel];
            timer_clear <= ~usb_q & ~ad_q;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_addr_match;
        state == cpp_pkg::ST_ADDR && scl_fall && cnt == cpp_pkg::BYTE_BITS && !start && !stop &&
            shreg[7:1] == cpp_pkg::SLAVE_ADDR;
    endsequence

    sequence s_unmapped_load;
        rd_load && ptr > cpp_pkg::REG_CTRL;
    endsequence

    addr_ack_a: assert property (s_addr_match |=> sda_oe && state == cpp_pkg::ST_ADDR_ACK)
        else $error("address match not acknowledged");
    unmapped_zero_a: assert property (s_unmapped_load |=> sda_oe && tx == 8'h00)
        else $error("unmapped read not zero");
    input_irq_a: assert property (masks[2] && (flags[1] || flags[0]) |=> int_oe)
        else $error("input change interrupt missing");
    touch_irq_a: assert property (masks[1] && flags[3] |=> int_oe)
        else $error("touch interrupt missing");
    int_release_a: assert property (!pending |=> !int_oe)
        else $error("interrupt pin not released");
    applied_flag_a: assert property (applied |=> flags[1])
        else $error("applied flag not set");
    removed_flag_a: assert property (removed |=> flags[0])
        else $error("removed flag not set");
    touch_flag_a: assert property (touch_rise |=> flags[3])
        else $error("touch flag not set");
    button_flag_a: assert property (btn_rise |=> flags[2])
        else $error("button flag not set");
    flag_clear_a: assert property (rd_clr && !applied |=> !flags[1])
        else $error("read did not clear flag");
    flag_hold_a: assert property (flags[0] && !rd_clr |=> flags[0])
        else $error("flag dropped without read");
    timer_clear_a: assert property (!usb_q && !ad_q |=> timer_clear)
        else $error("timers not cleared");
    adapter_ma_a: assert property (ctrl.adapter_ilim == 2'h2 |=> adapter_limit_ma == 12'h514)
        else $error("adapter limit wrong");
    usb_ma_a: assert property (ctrl.usb_ilim == 2'h2 |=> usb_limit_ma == 12'h320)
        else $error("usb limit wrong");
    ppath_write_a: assert property (wr_en && ptr == cpp_pkg::REG_PPATH && !usb_rm && !ad_rm
        |=> ctrl[13:8] == $past(wr_data[5:0]))
        else $error("power path write lost");
endmodule

// [test/cpp_host.sv]
`timescale 1ns/100ps

// serial bus master standing in for the host processor
module cpp_host (
    // clock used to pace the serial phases
    input wire logic mclk,
    // serial pins; sda_pull high pulls the data wire low
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // one serial clock phase, long enough for the slave's input filter
    task automatic half();
        repeat (8) @(negedge mclk);
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_pull = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b1;
        half();
        scl = 1'b0;
    endtask

    // stop: data rises while the clock is high, bus left idle
    task automatic stop();
        sda_pull = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b0;
        half();
    endtask

    // one bit; data only changes while the clock is low
    task automatic xfer(input logic b, output logic r);
        sda_pull = !b;
        half();
        scl = 1'b1;
        repeat (4) @(negedge mclk);
        r = sda;
        repeat (4) @(negedge mclk);
        scl = 1'b0;
    endtask

    // eight bits msb first, ninth bit released; ack is low on the wire
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], b);
            q[i] = b;
        end
        xfer(1'b1, b);
        ack = !b;
    endtask

    // pointer then one data byte; ok only if all three bytes were acked
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic k1;
        logic k2;
        logic k3;
        start();
        xbyte({a, 1'b0}, q, k1);
        xbyte(p, q, k2);
        xbyte(d, q, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask

    // pointer write, repeated start, one byte read ended by a nack
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] q;
        logic k;
        start();
        xbyte({cpp_pkg::SLAVE_ADDR, 1'b0}, q, k);
        xbyte(p, q, k);
        start();
        xbyte({cpp_pkg::SLAVE_ADDR, 1'b1}, q, k);
        xbyte(8'hff, d, k);
        stop();
    endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/100ps

module tb_top;
    // stimulus, all driven on the falling edge
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic usb_present = 1'b0;
    logic adapter_present = 1'b0;
    logic touch_detect = 1'b0;
    logic pushbutton_input_n = 1'b1;
    logic button_active_high = 1'b0;
    cpp_pkg::cpp_status_s charger_state = '0;
    // design outputs and resolved pins
    logic sda_out;
    logic sda_oe;
    logic int_out;
    logic int_oe;
    logic scl;
    logic sda_pull;
    cpp_pkg::cpp_ctrl_s ctrl;
    logic [11:0] adapter_limit_ma;
    logic [11:0] usb_limit_ma;
    logic [3:0] timer_hours;
    logic timer_clear;
    wire logic sda = (sda_oe ? sda_out : 1'b1) & !sda_pull;
    wire logic int_n = int_oe ? int_out : 1'b1;
    // bookkeeping and expected tables
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [11:0] ad_ma [4] = '{12'h064, 12'h1f4, 12'h514, 12'h9c4};
    logic [11:0] usb_ma [4] = '{12'h064, 12'h1f4, 12'h320, 12'h514};
    logic [3:0] hrs [4] = '{4'h4, 4'h5, 4'h6, 4'h8};

    always #4 mclk = ~mclk;

    cpp_regs u_dut (
        .mclk(mclk),
        .rstn(rstn),
        .scl(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .int_out(int_out),
        .int_oe(int_oe),
        .usb_present(usb_present),
        .adapter_present(adapter_present),
        .charger_state(charger_state),
        .touch_detect(touch_detect),
        .pushbutton_input_n(pushbutton_input_n),
        .button_active_high(button_active_high),
        .ctrl(ctrl),
        .adapter_limit_ma(adapter_limit_ma),
        .usb_limit_ma(usb_limit_ma),
        .timer_hours(timer_hours),
        .timer_clear(timer_clear)
    );

    cpp_host u_host (
        .mclk(mclk),
        .scl(scl),
        .sda_pull(sda_pull),
        .sda(sda)
    );

    // compare one value and count it
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // register write at our own address, every byte must be acked
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        u_host.wr(cpp_pkg::SLAVE_ADDR, p, d, ok);
        chk("write ack", 16'h1, 16'(ok));
    endtask

    // let a sense input pass the filter and the flag stage
    task automatic settle();
        repeat (12) @(negedge mclk);
    endtask

    // wait a bounded time for the interrupt pin to fall
    task automatic wait_int();
        for (int i = 0; i < 40; i++) begin
            if (int_n === 1'b0) break;
            @(negedge mclk);
        end
    endtask

    // values loaded by reset, unmapped read
    task automatic t_reset();
        logic [7:0] d;
        chk("ctrl", {2'h0, 6'h0d, 8'h31}, 16'(ctrl));
        u_host.rd(cpp_pkg::REG_CTRL, d);
        chk("charger_control", 16'h31, 16'(d));
        u_host.rd(cpp_pkg::REG_INT, d);
        chk("interrupt register", 16'h00, 16'(d));
        u_host.rd(cpp_pkg::REG_PPATH, d);
        chk("power_path_control", 16'h0d, 16'(d));
        u_host.rd(8'h07, d);
        chk("unmapped read", 16'h00, 16'(d));
        chk("timer_clear", 16'h1, 16'(timer_clear));
        chk("interrupt pin", 16'h1, 16'(int_n));
    endtask

    // presence bits, suspends and every current limit code
    task automatic t_power();
        logic [7:0] d;
        logic [1:0] c;
        usb_present = 1'b1;
        settle();
        u_host.rd(cpp_pkg::REG_PPATH, d);
        chk("usb present", 16'h8d, 16'(d));
        chk("timer_clear", 16'h0, 16'(timer_clear));
        chk("masked input pin", 16'h1, 16'(int_n));
        adapter_present = 1'b1;
        settle();
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(cpp_pkg::REG_PPATH, {2'b00, c[0], c[1], c, c});
            chk("suspends and limits", 16'({c[0], c[1], c, c}), 16'(ctrl[13:8]));
            chk("adapter limit", 16'(ad_ma[i]), 16'(adapter_limit_ma));
            chk("usb limit", 16'(usb_ma[i]), 16'(usb_limit_ma));
            u_host.rd(cpp_pkg::REG_PPATH, d);
            chk("power_path_control", 16'({2'b11, c[0], c[1], c, c}), 16'(d));
        end
    endtask

    // flags, masks and the interrupt pin
    task automatic t_irq();
        logic [7:0] d;
        u_host.rd(cpp_pkg::REG_INT, d);
        wr(cpp_pkg::REG_INT, 8'he0);
        adapter_present = 1'b0;
        wait_int();
        chk("interrupt pin", 16'h0, 16'(int_n));
        u_host.rd(cpp_pkg::REG_INT, d);
        chk("removed flag", 16'he1, 16'(d));
        chk("interrupt pin", 16'h1, 16'(int_n));
        adapter_present = 1'b1;
        wait_int();
        u_host.rd(cpp_pkg::REG_INT, d);
        chk("applied flag", 16'he2, 16'(d));
        touch_detect = 1'b1;
        settle();
        touch_detect = 1'b0;
        wait_int();
        chk("interrupt pin", 16'h0, 16'(int_n));
        u_host.rd(cpp_pkg::REG_INT, d);
        chk("touch flag", 16'he8, 16'(d));
        pushbutton_input_n = 1'b0;
        wait_int();
        chk("interrupt pin", 16'h0, 16'(int_n));
        u_host.rd(cpp_pkg::REG_INT, d);
        pushbutton_input_n = 1'b1;
        chk("button flag", 16'he4, 16'(d));
        wr(cpp_pkg::REG_INT, 8'h00);
        touch_detect = 1'b1;
        settle();
        touch_detect = 1'b0;
        repeat (30) @(negedge mclk);
        chk("masked pin", 16'h1, 16'(int_n));
        u_host.rd(cpp_pkg::REG_INT, d);
        chk("masked touch flag", 16'h08, 16'(d));
        // active-high button option: polarity and pin move together, so no edge yet
        button_active_high = 1'b1;
        pushbutton_input_n = 1'b0;
        settle();
        pushbutton_input_n = 1'b1;
        settle();
        u_host.rd(cpp_pkg::REG_INT, d);
        chk("high button flag", 16'h04, 16'(d));
    endtask

    // read-only status follows the charger and ignores writes
    task automatic t_status();
        logic [7:0] d;
        logic [6:0] cs;
        for (int i = 0; i < 2; i++) begin
            cs = (i == 0) ? 7'h55 : 7'h2a;
            charger_state = cs;
            settle();
            u_host.rd(cpp_pkg::REG_STATUS, d);
            chk("charger_status", 16'({cs[6:3], 1'b0, cs[2:0]}), 16'(d));
        end
        wr(cpp_pkg::REG_STATUS, 8'hff);
        u_host.rd(cpp_pkg::REG_STATUS, d);
        chk("status after write", 16'h52, 16'(d));
    endtask

    // timer codes, control bits, charger restart, foreign address
    task automatic t_ctrl();
        logic [7:0] d;
        logic [7:0] v;
        logic [1:0] c;
        logic ok;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            v = {c, c[0], 1'b1, 1'b0, c[1], c[0], !c[0]};
            wr(cpp_pkg::REG_CTRL, v);
            chk("timer hours", 16'(hrs[i]), 16'(timer_hours));
            chk("ctrl", 16'(v), 16'(ctrl[7:0]));
            u_host.rd(cpp_pkg::REG_CTRL, d);
            chk("charger_control", 16'(v), 16'(d));
        end
        wr(cpp_pkg::REG_CTRL, 8'h39);
        chk("charger reset", 16'h1, 16'(ctrl.charger_reset));
        wr(cpp_pkg::REG_CTRL, 8'h31);
        chk("charger reset", 16'h0, 16'(ctrl.charger_reset));
        u_host.wr(7'h49, cpp_pkg::REG_CTRL, 8'h00, ok);
        chk("foreign address ack", 16'h0, 16'(ok));
        chk("ctrl kept", 16'h31, 16'(ctrl[7:0]));
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            summarize();
        end
    end

    // main sequence
    initial begin
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        repeat (8) @(negedge mclk);
        t_reset();
        t_power();
        t_irq();
        t_status();
        t_ctrl();
        summarize();
    end
endmodule
